// file: hw/sacr_regs.svh
// Constants for the converter control and serial readout block
`ifndef SACR_REGS_SVH
`define SACR_REGS_SVH
`define SACR_RES_BITS 18
`define SACR_CLK_PERIOD_NS 5
`define SACR_CONV_TIME_NS 360
`define SACR_CONV_CYCLES ((`SACR_CONV_TIME_NS + `SACR_CLK_PERIOD_NS - 1) / `SACR_CLK_PERIOD_NS)
`define SACR_EN_TIME_NS 16
`define SACR_EN_CYCLES (`SACR_EN_TIME_NS / `SACR_CLK_PERIOD_NS)
`define SACR_STEP_CYCLES 20
`define SACR_GC_OFFSET 18'h0cccc
`endif

// file: hw/sacr_pkg.sv
// Types for the converter control and serial readout block
package sacr_pkg;
    typedef enum logic [1:0] {SACR_SLEEP, SACR_CONVERT, SACR_READY} sacr_phase_t;
endpackage

// file: hw/sacr_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module sacr_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q; // First stage, read only by second stage
    logic [WIDTH-1:0] sync_q; // Second stage
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // Next values: straight shift
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Register both stages
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // sacr_sync

// file: hw/sacr_core.sv
// Conversion sequencer and serial readout of an 18-bit SAR converter
// Behaviour
// - Chain low: read enable gates serial output
// - Chain high: pin becomes daisy-chain serial input
// - Convert strobe rising edge starts conversion
// - Busy high during conversion, low after
// - Shift result MSB first per SCK rise
// - Result is two's-complement code
// - Eighteen-bit output word per conversion
// - Compression select low enables compressed range
// - Compression rescales codes toward 0.1/0.9 reference
// - Step binary-weighted search, load output shifter
// - Alternate acquisition and conversion phases
// - Conversion timed by internal counter
// - Result available as conversion ends
// - Sleep between conversions
// - Output enable within 16 ns, active low
// - First bit valid as busy falls
`timescale 1ns/10ps
`include "sacr_regs.svh"
module sacr_core #(
    parameter int RES = `SACR_RES_BITS,
    parameter int STEP_CYCLES = `SACR_STEP_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic convert_strobe_in,
    input wire logic sck_in,
    input wire logic read_enable_or_chain_in,
    input wire logic chain_select_in,
    input wire logic gain_compression_select_in,
    input wire logic signed [RES-1:0] sample_in, // Analog sample as ideal code
    output logic busy_out,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic powered_out
);
    // Synchronised pins: strobe, sck, read/chain, chain sel, compression sel
    logic [4:0] pins_s;
    sacr_sync #(.WIDTH(5)) u_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .async_in({gain_compression_select_in, chain_select_in, read_enable_or_chain_in,
                   sck_in, convert_strobe_in}),
        .sync_out(pins_s)
    );
    logic cnv_s, sck_s, rdsdi_s, chain_s, gcsel_s;
    assign cnv_s = pins_s[0];
    assign sck_s = pins_s[1];
    assign rdsdi_s = pins_s[2];
    assign chain_s = pins_s[3];
    assign gcsel_s = pins_s[4];

    sacr_pkg::sacr_phase_t phase_q, phase_d; // Acquire/sleep vs convert
    logic cnv_prev_q, cnv_prev_d; // Edge detect on strobe
    logic sck_prev_q, sck_prev_d; // Edge detect on sck
    logic [RES-1:0] trial_q, trial_d; // Successive approximation register
    logic [RES-1:0] weight_q, weight_d; // Current trial bit
    logic [RES-1:0] held_q, held_d; // Sample held at strobe edge
    logic [15:0] step_q, step_d; // Internal oscillator divider
    logic [RES-1:0] shift_q, shift_d; // Output shifter
    logic busy_q, busy_d;
    logic sdo_q, sdo_d;
    logic oe_q, oe_d;
    logic pwr_q, pwr_d;
    logic cnv_rise, sck_rise;
    logic [RES-1:0] offs_unsigned; // Sample in offset binary for the search
    logic [RES-1:0] result_code; // Final two's-complement result
    logic [RES-1:0] final_trial; // Search word including this step's decision
    logic [RES+2:0] scaled; // Compression product

    assign cnv_rise = cnv_s & ~cnv_prev_q;
    assign sck_rise = sck_s & ~sck_prev_q;
    // Offset binary lets a plain unsigned compare do the search
    assign offs_unsigned = {~sample_in[RES-1], sample_in[RES-2:0]};

    // Last decision taken here from registers, so the result path has no comb loop
    assign final_trial = ((trial_q | weight_q) <= held_q) ? (trial_q | weight_q) : trial_q;

    // Compression: result = code*0.8 + 0.1 span, i.e. code*4/5, kept signed
    always_comb begin
        scaled = '0;
        result_code = final_trial ^ {1'b1, {(RES-1){1'b0}}}; // Back to two's complement
        if (!gcsel_s) begin // Select tied low enables compression
            // Signed math so negative codes truncate toward zero, not wrap
            scaled = (RES+3)'(($signed({{3{result_code[RES-1]}}, result_code}) * 4) / 5);
            result_code = scaled[RES-1:0];
        end
    end

    // Sequencer and shifter next state
    always_comb begin
        phase_d = phase_q;
        cnv_prev_d = cnv_s;
        sck_prev_d = sck_s;
        trial_d = trial_q;
        weight_d = weight_q;
        held_d = held_q;
        step_d = step_q;
        shift_d = shift_q;
        busy_d = busy_q;
        pwr_d = pwr_q;
        unique case (phase_q)
            sacr_pkg::SACR_SLEEP, sacr_pkg::SACR_READY: begin
                // Acquisition: inputs tracked, core powered down
                pwr_d = 1'b0;
                if (cnv_rise) begin
                    phase_d = sacr_pkg::SACR_CONVERT;
                    held_d = offs_unsigned;
                    trial_d = '0;
                    weight_d = {1'b1, {(RES-1){1'b0}}};
                    step_d = '0;
                    busy_d = 1'b1;
                    pwr_d = 1'b1;
                end
            end
            sacr_pkg::SACR_CONVERT: begin
                step_d = step_q + 16'h0001; // Internal timebase
                if (step_q == 16'(STEP_CYCLES - 1)) begin
                    step_d = '0;
                    // Keep trial bit if sample is at or above it
                    if ((trial_q | weight_q) <= held_q) begin
                        trial_d = trial_q | weight_q;
                    end
                    weight_d = weight_q >> 1;
                    if (weight_q[0]) begin
                        // Last bit decided: load shifter this very edge
                        phase_d = sacr_pkg::SACR_READY;
                        busy_d = 1'b0;
                        pwr_d = 1'b0; // Power down as the result lands
                        shift_d = result_code;
                    end
                end
            end
            default: phase_d = sacr_pkg::SACR_SLEEP;
        endcase
        // Shift on sck rising edge when output active
        if (phase_q != sacr_pkg::SACR_CONVERT && sck_rise && (chain_s || !rdsdi_s)) begin
            // Chain mode fills from upstream, normal pads zero
            shift_d = {shift_q[RES-2:0], chain_s ? rdsdi_s : 1'b0};
        end
    end

    // Output pin next values
    always_comb begin
        sdo_d = shift_d[RES-1]; // MSB presented first
        // Chain mode always drives; normal drives on low enable
        oe_d = chain_s | ~rdsdi_s;
    end

    // Register all state
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= sacr_pkg::SACR_SLEEP;
            cnv_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
            trial_q <= '0;
            weight_q <= '0;
            held_q <= '0;
            step_q <= '0;
            shift_q <= '0;
            busy_q <= 1'b0;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            pwr_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cnv_prev_q <= cnv_prev_d;
            sck_prev_q <= sck_prev_d;
            trial_q <= trial_d;
            weight_q <= weight_d;
            held_q <= held_d;
            step_q <= step_d;
            shift_q <= shift_d;
            busy_q <= busy_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            pwr_q <= pwr_d;
        end
    end

    assign busy_out = busy_q;
    assign sdo_out = sdo_q;
    assign sdo_oe_out = oe_q;
    assign powered_out = pwr_q;

    // Checks
    a_busy_rise: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (cnv_rise && phase_q != sacr_pkg::SACR_CONVERT) |=> busy_q)
        else $error("busy did not rise on strobe");
    a_busy_len: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(busy_q) |-> busy_q [*8])
        else $error("conversion ended too early");
    a_busy_end: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(busy_q) |-> ##[1:400] !busy_q)
        else $error("conversion never ended");
    // Uncompressed result must equal the held sample, found by the search
    a_first_bit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ($fell(busy_q) && $past(gcsel_s)) |-> (sdo_q == shift_q[RES-1]
        && shift_q == (held_q ^ {1'b1, {(RES-1){1'b0}}})))
        else $error("result not on sdo at busy fall");
    a_oe_normal: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (!chain_s && rdsdi_s) |=> !oe_q)
        else $error("sdo driven while disabled");
    a_oe_enable: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (!chain_s && !rdsdi_s) |=> oe_q)
        else $error("sdo not enabled");
    a_shift_step: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (sck_rise && !busy_q && !busy_d && oe_d) |=> shift_q[RES-1] == $past(shift_q[RES-2]))
        else $error("shifter did not advance");
    a_chain_in: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (sck_rise && chain_s && phase_q == sacr_pkg::SACR_READY && !cnv_rise)
        |=> shift_q[0] == $past(rdsdi_s))
        else $error("chain bit not captured");
    a_conv_time: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(busy_q) |-> ##300 busy_q)
        else $error("conversion shorter than its timebase");
    a_shift_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (busy_q && busy_d) |=> shift_q == $past(shift_q))
        else $error("shifter moved during conversion");
    c_conv: cover property (@(posedge clock_in) $fell(busy_q));
    c_chain: cover property (@(posedge clock_in) sck_rise && chain_s);
    c_gc: cover property (@(posedge clock_in) $fell(busy_q) && !gcsel_s);
endmodule // sacr_core

// file: testbench/sacr_host_model.sv
// Host model: serial clock, result capture and upstream chain data
`timescale 1ns/10ps
module sacr_host_model (
    output logic sck_out,
    output logic chain_out,
    input wire logic sdo_in
);
    initial sck_out = 1'b0; // Clock stands low between frames
    initial chain_out = 1'b0; // Upstream line idles low
    // Clocks n bits; upstream word goes out MSB first, then the line toggles
    task automatic read(input int n, input logic [17:0] up, output logic [35:0] w);
        w = 36'h0;
        for (int i = 0; i < n; i++) begin
            chain_out = (i < 18) ? up[17 - i] : ~chain_out; // Stale data never repeats
            w = {w[34:0], sdo_in}; // Bit settled well before the rise
            #80 sck_out = 1'b1; // Frames start long after strobe 160 ns period
            #80 sck_out = 1'b0;
        end
    endtask
endmodule // sacr_host_model

// file: testbench/test_sar_adc_convert_and_serial_readout.sv
// Self-checking bench for the converter sequencer and serial readout
`timescale 1ns/10ps
module test_sar_adc_convert_and_serial_readout;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic convert_strobe = 1'b0; // Convert strobe pin
    logic chain = 1'b0; // Chain mode select
    logic gcs = 1'b1; // High leaves compression off
    logic ren_n = 1'b1; // Active-low output enable
    logic [17:0] smp = 18'h0; // Ideal code of the analog input
    logic busy, sdo, oe, pwr, sck, up_bit;
    logic [35:0] busy_len = 36'h0; // Cycles seen with busy high
    logic [35:0] w; // Word gathered by the host
    logic [17:0] tbl [4] = '{18'h1a5c3, 18'h20000, 18'h3fc18, 18'h1ffff}; // Edge codes
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    // One pin carries the enable or the upstream bits, by mode
    wire logic rdl = chain ? up_bit : ren_n;
    // Released line shows the inverse, so a read also proves the enable
    wire logic sdo_bus = oe ? sdo : ~sdo;
    always #2.5 clock_in = ~clock_in;
    sacr_core uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .convert_strobe_in(convert_strobe),
        .sck_in(sck), .read_enable_or_chain_in(rdl), .chain_select_in(chain),
        .gain_compression_select_in(gcs), .sample_in(smp), .busy_out(busy),
        .sdo_out(sdo), .sdo_oe_out(oe), .powered_out(pwr));
    sacr_host_model host (.sck_out(sck), .chain_out(up_bit), .sdo_in(sdo_bus));
    // Busy length and hang guard; a hang counts as a mismatch
    always @(posedge clock_in) begin
        cyc++;
        if (busy === 1'b1) busy_len++;
        if (cyc == 30000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Expected code: scaled by 4/5 toward zero when compression is on
    function automatic logic [17:0] exp_code(input logic [17:0] s, input logic g);
        int v;
        v = int'($signed(s));
        if (!g) v = (v * 4) / 5;
        return v[17:0];
    endfunction
    // One conversion; optionally a stray strobe mid-way, which must be ignored
    task automatic run_conv(input logic [17:0] s, input logic g, input logic twice);
        int n;
        busy_len = 36'h0;
        @(negedge clock_in);
        smp = s;
        gcs = g;
        convert_strobe = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clock_in);
            n++;
        end
        check(pwr, 1'b1);
        repeat (4) @(negedge clock_in);
        convert_strobe = 1'b0;
        if (twice) begin
            repeat (40) @(negedge clock_in);
            convert_strobe = 1'b1;
            repeat (4) @(negedge clock_in);
            convert_strobe = 1'b0;
        end
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge clock_in);
            n++;
        end
        check(busy_len, 36'd360);
        check(pwr, 1'b0);
    endtask
    // Enable pin toggled: output released, then driven again
    task automatic enable_test();
        chain = 1'b0;
        ren_n = 1'b1;
        repeat (4) @(negedge clock_in);
        check(oe, 1'b0);
        ren_n = 1'b0;
        repeat (4) @(negedge clock_in);
        check(oe, 1'b1);
    endtask
    // Normal-mode reads of edge codes, compression off and on
    task automatic normal_test();
        for (int i = 0; i < 4; i++) begin
            run_conv(tbl[i], i[0], i == 1);
            host.read(18, 18'h0, w);
            check(w, {18'h0, exp_code(tbl[i], i[0])});
        end
    endtask
    // Chain mode: upstream word must follow our own bits
    task automatic chain_test();
        chain = 1'b1;
        run_conv(18'h0f0f3, 1'b1, 1'b0);
        host.read(36, 18'h2d4b1, w);
        check(w, {18'h0f0f3, 18'h2d4b1});
    endtask
    initial begin
        repeat (16) @(negedge clock_in);
        rst_n_in = 1'b1;
        check(pwr, 1'b0);
        enable_test();
        normal_test();
        chain_test();
        print_verdict();
    end
endmodule // test_sar_adc_convert_and_serial_readout
